// *** cpd_mem.sv ***
// Small pixel store with one write port and a registered read port.
`timescale 1ns/1ps
`default_nettype none

module cpd_mem #(
    parameter int WIDTH = 12,
    parameter int WORDS = 3,
    parameter int AW    = 2
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             we,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);

    logic [WIDTH-1:0] word [WORDS];

    // Each entry clears at reset so the display never shows unknown data.
    for (genvar i = 0; i < WORDS; i++) begin : g_word
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                word[i] <= '0;
            end else if (we && (wr_addr == AW'(i))) begin
                word[i] <= wr_data;
            end
        end
    end

    // Read data always comes out of a register.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_data <= '0;
        end else begin
            rd_data <= word[rd_addr];
        end
    end

endmodule // cpd_mem

`default_nettype wire

// *** cpd_pkg.sv ***
// Types shared by the cascade LED pixel driver.
package cpd_pkg;

    // Transmit bit cell sequencer states.
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_HIGH = 2'b01,
        TX_LOW  = 2'b10
    } cpd_tx_state_e;

endpackage

// *** cpd_regs.svh ***
// Constants for the cascade LED pixel driver: timing, framing and widths.
`ifndef CPD_REGS_SVH
`define CPD_REGS_SVH

`define CPD_CLK_MHZ      125
`define CPD_NS_PER_US    1000
`define CPD_BIT_MIN_NS   1000
`define CPD_BIT_MAX_NS   1500
`define CPD_THRESH_NS    600
`define CPD_T0H_NS       300
`define CPD_T1H_NS       900
`define CPD_GAP_NS       50000
`define CPD_LOSS_NS      100000000
`define CPD_FLAG_BITS    8
`define CPD_FLAG_VALUE   8'hA5
`define CPD_CHAN         3
`define CPD_DEPTH_BITS   12
`define CPD_MAX_PIXELS   1024
`define CPD_CNT_W        8
`define CPD_BITCNT_W     16

`endif

// *** cpd_top.sv ***
// Cascade LED pixel driver: receive, check, re-encode, store and display.
`timescale 1ns/1ps
`default_nettype none
`include "cpd_regs.svh"

// Summary of operation
// - Recover bit rate and data from cascade_in.
// - Judge frame by period and flag; flag fault.
// - Fault on input loss and on corrupt input.
// - Send PWM bit cells on cascade_out.
// - Re-encode with own timing, no pass-through.
// - Chain holds at most 1024 pixels.
// - Three colour drive outputs, slot order fixed.
// - Colour outputs drive low to light.
// - Store pixel, display reads it in sequence.
module cpd_top #(
    parameter int GAP_CYC    = (`CPD_GAP_NS * `CPD_CLK_MHZ
                                + `CPD_NS_PER_US - 1) / `CPD_NS_PER_US,
    parameter int LOSS_CYC   = int'((64'(`CPD_LOSS_NS) * `CPD_CLK_MHZ)
                                / `CPD_NS_PER_US),
    parameter int DEPTH      = `CPD_DEPTH_BITS,
    parameter int MAX_PIXELS = `CPD_MAX_PIXELS
) (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic cascade_in,
    output logic      cascade_out,
    output logic      red_drive_n,
    output logic      green_drive_n,
    output logic      blue_drive_n,
    output logic      fault_indicator_out
);

    localparam int CW       = `CPD_CNT_W;
    localparam int BW       = `CPD_BITCNT_W;
    localparam int CHAN     = `CPD_CHAN;
    localparam int FLAGB    = `CPD_FLAG_BITS;
    localparam int PIXB     = CHAN * DEPTH;
    localparam int MAXB     = FLAGB + PIXB * MAX_PIXELS;
    localparam int LW       = $clog2(GAP_CYC + 1);
    localparam int OW       = $clog2(LOSS_CYC + 1);
    localparam int BIT_MIN  = (`CPD_BIT_MIN_NS * `CPD_CLK_MHZ
                               + `CPD_NS_PER_US - 1) / `CPD_NS_PER_US;
    localparam int BIT_MAX  = `CPD_BIT_MAX_NS * `CPD_CLK_MHZ / `CPD_NS_PER_US;
    localparam int THRESH   = `CPD_THRESH_NS * `CPD_CLK_MHZ / `CPD_NS_PER_US;
    localparam int T0H      = (`CPD_T0H_NS * `CPD_CLK_MHZ
                               + `CPD_NS_PER_US - 1) / `CPD_NS_PER_US;
    localparam int T1H      = (`CPD_T1H_NS * `CPD_CLK_MHZ
                               + `CPD_NS_PER_US - 1) / `CPD_NS_PER_US;
    localparam int TX_BIT   = BIT_MIN;
    localparam logic [FLAGB-1:0] FLAG = `CPD_FLAG_VALUE;

    // Receive side state.
    logic             sync1;
    logic             sync2;
    logic             in_q;
    logic [CW-1:0]    hi_cnt;
    logic [CW-1:0]    per_cnt;
    logic [LW-1:0]    low_cnt;
    logic [OW-1:0]    loss_cnt;
    logic [BW-1:0]    bit_cnt;
    logic [FLAGB-1:0] flag_sr;
    logic [PIXB-1:0]  pix_sr;
    logic             in_frame;
    logic             rx_err;
    logic             wr_busy;
    logic [1:0]       wr_idx;
    // Transmit side state.
    logic             pend_valid;
    logic             pend_bit;
    logic             tx_bit;
    logic [CW-1:0]    tx_cnt;
    cpd_pkg::cpd_tx_state_e tx_state;
    cpd_pkg::cpd_tx_state_e next_tx_state;
    // Display side state.
    logic [DEPTH-1:0] pwm_cnt;
    logic [DEPTH-1:0] duty [CHAN];
    logic [1:0]       rd_idx;
    logic [1:0]       rd_idx_q;
    logic [DEPTH-1:0] rd_data;
    logic [DEPTH-1:0] slot_word [CHAN];
    logic [CHAN-1:0]  drive_n;

    // Edges, bit decisions and frame boundaries from the synchronised line.
    wire rise      = sync2 & ~in_q;
    wire fall      = ~sync2 & in_q;
    wire bit_val   = (hi_cnt >= CW'(THRESH));
    wire bit_stb   = in_frame & fall;
    wire per_bad   = in_frame & rise & ((per_cnt < CW'(BIT_MIN))
                                        | (per_cnt > CW'(BIT_MAX)));
    wire hi_bad    = in_frame & sync2 & (hi_cnt > CW'(BIT_MAX));
    wire gap_hit   = in_frame & ~sync2 & (low_cnt == LW'(GAP_CYC - 1));
    wire in_flag   = (bit_cnt < BW'(FLAGB));
    wire in_pix    = ~in_flag & (bit_cnt < BW'(FLAGB + PIXB));
    wire in_chain  = (bit_cnt < BW'(MAXB));
    wire frame_ok  = gap_hit & ~rx_err & (flag_sr == FLAG)
                     & (bit_cnt >= BW'(FLAGB + PIXB));
    wire frame_bad = gap_hit & ~frame_ok;
    wire loss_hit  = (loss_cnt == OW'(LOSS_CYC - 1));
    wire loss_done = (loss_cnt == OW'(LOSS_CYC));
    wire fwd       = bit_stb & in_chain & ~in_pix;
    wire cell_end  = (tx_state == cpd_pkg::TX_LOW)
                     & (tx_cnt == CW'(TX_BIT - 1));
    wire hi_end    = (tx_state == cpd_pkg::TX_HIGH)
                     & (tx_cnt == (tx_bit ? CW'(T1H - 1) : CW'(T0H - 1)));
    wire take      = pend_valid & ((tx_state == cpd_pkg::TX_IDLE) | cell_end);

    // Two flip-flops bring the line into the clock domain.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sync1 <= '0;
            sync2 <= '0;
            in_q  <= '0;
        end else begin
            sync1 <= cascade_in;
            sync2 <= sync1;
            in_q  <= sync2;
        end
    end

    // High time, rise-to-rise period and low time, all saturating.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hi_cnt  <= '0;
            per_cnt <= '0;
            low_cnt <= '0;
        end else begin
            hi_cnt  <= rise ? CW'(1) : (sync2 && hi_cnt != '1)
                       ? hi_cnt + CW'(1) : hi_cnt;
            per_cnt <= rise ? CW'(1) : (per_cnt != '1)
                       ? per_cnt + CW'(1) : per_cnt;
            low_cnt <= sync2 ? '0 : (low_cnt != LW'(GAP_CYC - 1))
                       ? low_cnt + LW'(1) : low_cnt;
        end
    end

    // Frame tracking, bit counting, flag and pixel capture.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            in_frame <= '0;
            rx_err   <= '0;
            bit_cnt  <= '0;
            flag_sr  <= '0;
            pix_sr   <= '0;
        end else if (!in_frame) begin
            in_frame <= rise;
            rx_err   <= '0;
            bit_cnt  <= '0;
        end else if (gap_hit) begin
            in_frame <= '0;
        end else begin
            rx_err <= rx_err | per_bad | hi_bad;
            if (bit_stb && in_chain) begin
                bit_cnt <= bit_cnt + BW'(1);
            end
            if (bit_stb && in_flag) begin
                flag_sr <= {flag_sr[FLAGB-2:0], bit_val};
            end
            if (bit_stb && in_pix) begin
                pix_sr <= {pix_sr[PIXB-2:0], bit_val};
            end
        end
    end

    // Loss timer restarts on every good frame. It rests one past the trip
    // count, so the loss verdict is a single pulse and a good frame clears.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            loss_cnt <= '0;
        end else if (frame_ok) begin
            loss_cnt <= '0;
        end else if (!loss_done) begin
            loss_cnt <= loss_cnt + OW'(1);
        end
    end

    // Fault output: any set wins over the clear of a good frame.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fault_indicator_out <= '0;
        end else if (loss_hit || frame_bad) begin
            fault_indicator_out <= '1;
        end else if (frame_ok) begin
            fault_indicator_out <= '0;
        end
    end

    // A good frame is copied into the store one slot per cycle.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_busy <= '0;
            wr_idx  <= '0;
        end else if (frame_ok) begin
            wr_busy <= '1;
            wr_idx  <= '0;
        end else if (wr_busy) begin
            wr_busy <= (wr_idx != 2'(CHAN - 1));
            wr_idx  <= (wr_idx != 2'(CHAN - 1)) ? wr_idx + 2'(1) : wr_idx;
        end
    end

    // One bit waits here while the previous cell is still on the line.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pend_valid <= '0;
            pend_bit   <= '0;
        end else if (fwd) begin
            pend_valid <= '1;
            pend_bit   <= bit_val;
        end else if (take) begin
            pend_valid <= '0;
        end
    end

    // Bit cell sequencer: own-timed high part, then low to the cell length.
    always_comb begin
        next_tx_state = tx_state;
        case (tx_state)
            cpd_pkg::TX_IDLE: begin
                if (take) next_tx_state = cpd_pkg::TX_HIGH;
            end
            cpd_pkg::TX_HIGH: begin
                if (hi_end) next_tx_state = cpd_pkg::TX_LOW;
            end
            cpd_pkg::TX_LOW: begin
                if (cell_end) next_tx_state = take ? cpd_pkg::TX_HIGH
                                                   : cpd_pkg::TX_IDLE;
            end
            default: next_tx_state = cpd_pkg::TX_IDLE;
        endcase
    end

    // Cell counter, bit in flight and the regenerated line.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tx_state    <= cpd_pkg::TX_IDLE;
            tx_cnt      <= '0;
            tx_bit      <= '0;
            cascade_out <= '0;
        end else begin
            tx_state    <= next_tx_state;
            tx_cnt      <= (take || hi_end) ? (take ? '0 : tx_cnt + CW'(1))
                           : tx_cnt + CW'(1);
            tx_bit      <= take ? pend_bit : tx_bit;
            cascade_out <= (next_tx_state == cpd_pkg::TX_HIGH);
        end
    end

    cpd_mem #(
        .WIDTH (DEPTH),
        .WORDS (CHAN),
        .AW    (2)
    ) u_mem (
        .clock   (clock),
        .rst     (rst),
        .we      (wr_busy),
        .wr_addr (wr_idx),
        .wr_data (slot_word[wr_idx]),
        .rd_addr (rd_idx),
        .rd_data (rd_data)
    );

    // Display reads slots round robin and runs a free PWM counter.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_idx   <= '0;
            rd_idx_q <= '0;
            pwm_cnt  <= '0;
        end else begin
            rd_idx   <= (rd_idx == 2'(CHAN - 1)) ? '0 : rd_idx + 2'(1);
            rd_idx_q <= rd_idx;
            pwm_cnt  <= pwm_cnt + DEPTH'(1);
        end
    end

    // Per channel: slot word, duty value and active-low drive.
    for (genvar k = 0; k < CHAN; k++) begin : g_chan
        assign slot_word[k] = pix_sr[(CHAN-1-k)*DEPTH +: DEPTH];
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                duty[k]    <= '0;
                drive_n[k] <= '1;
            end else begin
                if (rd_idx_q == 2'(k)) duty[k] <= rd_data;
                drive_n[k] <= ~(pwm_cnt < duty[k]);
            end
        end
    end

    // Slot 0 is red, 1 green, 2 blue; the controller orders its data.
    assign red_drive_n   = drive_n[0];
    assign green_drive_n = drive_n[1];
    assign blue_drive_n  = drive_n[2];

    // Checks on the receive verdicts and the outputs.
    sequence s_good_end;
        (frame_ok && !loss_hit) ##1 wr_busy;
    endsequence
    property p_loss;
        @(posedge clock) disable iff (rst) loss_hit |=> fault_indicator_out;
    endproperty
    a_loss: assert property (p_loss) else $error("loss not flagged");
    property p_bad;
        @(posedge clock) disable iff (rst) frame_bad |=> fault_indicator_out;
    endproperty
    a_bad: assert property (p_bad) else $error("bad frame not flagged");
    property p_clear;
        @(posedge clock) disable iff (rst)
            s_good_end |-> !fault_indicator_out ##1 wr_busy ##1 wr_busy;
    endproperty
    a_clear: assert property (p_clear) else $error("fault or store");
    property p_period;
        @(posedge clock) disable iff (rst)
            per_bad && !gap_hit |=> rx_err [*2];
    endproperty
    a_period: assert property (p_period) else $error("period unchecked");
    property p_chain;
        @(posedge clock) disable iff (rst) bit_cnt <= BW'(MAXB);
    endproperty
    a_chain: assert property (p_chain) else $error("chain overrun");
    property p_cell_hi;
        @(posedge clock) disable iff (rst)
            $fell(cascade_out) |-> $past(tx_cnt) ==
                ($past(tx_bit) ? CW'(T1H - 1) : CW'(T0H - 1));
    endproperty
    a_cell_hi: assert property (p_cell_hi) else $error("high time");
    property p_cell_len;
        @(posedge clock) disable iff (rst)
            $rose(cascade_out) && $past(tx_state) == cpd_pkg::TX_LOW
            |-> $past(tx_cnt) == CW'(TX_BIT - 1);
    endproperty
    a_cell_len: assert property (p_cell_len) else $error("cell length");
    property p_dark;
        @(posedge clock) disable iff (rst)
            (duty[0] == '0) [*2] |-> red_drive_n;
    endproperty
    a_dark: assert property (p_dark) else $error("zero duty lit");
    property p_lit;
        @(posedge clock) disable iff (rst)
            pwm_cnt == '0 && duty[1] != '0 |=> !green_drive_n;
    endproperty
    a_lit: assert property (p_lit) else $error("duty not shown");

endmodule // cpd_top

`default_nettype wire

// *** cpd_top_test.sv ***
// Self-checking bench for the cascade LED pixel driver.
`timescale 1ns/1ps
`default_nettype none

module cpd_top_test;
    localparam int GAP  = 200;
    localparam int LOSS = 30000;

    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        cascade_in;
    logic        cascade_out;
    logic        red_drive_n;
    logic        green_drive_n;
    logic        blue_drive_n;
    logic        fault_indicator_out;
    int          bad_count = 0;
    int          cmp_count = 0;
    logic [31:0] seed = 32'he29d;
    logic        exp_q[$];
    logic        watch = 1'b0;
    logic        nb;
    logic [31:0] hi_cnt = 32'h0;

    // The clock toggles every half period of 4 ns.
    always #4 clock = ~clock;

    cpd_upstream up_u (.clock(clock), .line(cascade_in));

    // Short gap and loss spans keep the run brief.
    cpd_top #(.GAP_CYC(GAP), .LOSS_CYC(LOSS), .MAX_PIXELS(2)) dut_u (
        .clock              (clock),
        .rst                (rst),
        .cascade_in         (cascade_in),
        .cascade_out        (cascade_out),
        .red_drive_n        (red_drive_n),
        .green_drive_n      (green_drive_n),
        .blue_drive_n       (blue_drive_n),
        .fault_indicator_out(fault_indicator_out)
    );

    // Steps the pseudo-random source.
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Compares a seen value with the expected one and counts both.
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Sends one frame; a good one notes the bits expected downstream,
    // which are the flag and the next pixel but never past the chain end.
    task automatic send(input logic [7:0] flag, input logic [35:0] own,
                        input int keep, input int slow, input logic good,
                        input logic exp_fault);
        logic [91:0] v;
        seed = lfsr_next(seed);
        v = {flag, own, seed[15:0], seed};
        watch = good;
        if (good) begin
            for (int i = 0; i < 8; i++) exp_q.push_back(v[91-i]);
            for (int i = 44; i < keep && i < 80; i++) exp_q.push_back(v[91-i]);
        end
        up_u.send_frame(v, keep, slow);
        repeat (GAP + 20) @(posedge clock);
        check("fault", {31'h0, fault_indicator_out}, {31'h0, exp_fault});
        if (good) check("fwd_left", 32'(exp_q.size()), 32'h0);
    endtask

    // Counts lit cycles of each drive over one full PWM period.
    task automatic measure(input logic [35:0] p);
        logic [31:0] r;
        logic [31:0] g;
        logic [31:0] b;
        r = 32'h0;
        g = 32'h0;
        b = 32'h0;
        repeat (4096) begin
            @(negedge clock);
            r = r + 32'(red_drive_n === 1'b0);
            g = g + 32'(green_drive_n === 1'b0);
            b = b + 32'(blue_drive_n === 1'b0);
        end
        check("red_duty", r, {20'h0, p[35:24]});
        check("green_duty", g, {20'h0, p[23:12]});
        check("blue_duty", b, {20'h0, p[11:0]});
    endtask

    // Times each forwarded cell and compares it with the oldest note.
    always @(posedge clock) begin
        if (cascade_out === 1'b1) begin
            hi_cnt <= hi_cnt + 32'h1;
        end else if (hi_cnt != 32'h0) begin
            hi_cnt <= 32'h0;
            if (watch && exp_q.size() == 0) begin
                check("fwd_extra", 32'h1, 32'h0);
            end else if (watch) begin
                nb = exp_q.pop_front();
                check("fwd_bit", 32'(hi_cnt > 75), {31'h0, nb});
                check("fwd_width", hi_cnt, nb ? 32'h71 : 32'h26);
            end
        end
    end

    // Main sequence: good, bad, boundary, short, slow frames, then loss.
    initial begin
        logic [35:0] p1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        check("fault_rst", {31'h0, fault_indicator_out}, 32'h0);
        check("drives_rst", {29'h0, red_drive_n, green_drive_n,
                             blue_drive_n}, 32'h7);
        seed = lfsr_next(seed);
        p1 = {seed[3:0], seed};
        send(8'ha5, p1, 92, -1, 1'b1, 1'b0);
        seed = lfsr_next(seed);
        send(8'h5a, {seed[3:0], seed}, 44, -1, 1'b0, 1'b1);
        measure(p1);
        send(8'ha5, {12'h0, 12'hfff, 12'h800}, 44, -1, 1'b1, 1'b0);
        repeat (10) @(posedge clock);
        measure({12'h0, 12'hfff, 12'h800});
        send(8'ha5, p1, 20, -1, 1'b0, 1'b1);
        send(8'ha5, p1, 56, -1, 1'b1, 1'b0);
        send(8'ha5, p1, 44, 30, 1'b0, 1'b1);
        send(8'ha5, p1, 44, -1, 1'b1, 1'b0);
        repeat (LOSS - 1000) @(posedge clock);
        check("fault_wait", {31'h0, fault_indicator_out}, 32'h0);
        repeat (1200) @(posedge clock);
        check("fault_loss", {31'h0, fault_indicator_out}, 32'h1);
        send(8'ha5, p1, 44, -1, 1'b1, 1'b0);
        report_and_stop();
    end

    // Cuts a hung run short about 5000 cycles after the sequence should have ended.
    initial begin
        repeat (100000) @(posedge clock);
        bad_count++;
        report_and_stop();
    end
endmodule // cpd_top_test

`default_nettype wire

// *** cpd_upstream.sv ***
// Upstream controller model that sends pixel frames on the cascade line.
`timescale 1ns/1ps
`default_nettype none

module cpd_upstream (
    input  wire logic clock,
    output logic      line
);
    // The line rests low between frames.
    initial line = 1'b0;

    // Sends n bits MSB first, slots in red, green, blue order, with a
    // period that wanders so the receiver sees fast and slow cells; bit
    // slow_idx gets an over-long period to corrupt the frame on purpose.
    task automatic send_frame(input logic [91:0] v, input int n,
                              input int slow_idx);
        int per;
        int hi;
        for (int i = 0; i < n; i++) begin
            per = (i == slow_idx) ? 200 : 126 + (i * 7) % 30;
            hi  = v[91-i] ? 80 + (i % 4) * 8 : 30 + (i % 3) * 5;
            @(posedge clock);
            line <= 1'b1;
            repeat (hi) @(posedge clock);
            line <= 1'b0;
            repeat (per - hi - 1) @(posedge clock);
        end
    endtask
endmodule // cpd_upstream

`default_nettype wire
